// file: pkg/panel_pkg.sv
// Constants and types of the panel image block
// Assumes a 25 MHz panel clock
package panel_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLOCK_HZ = 25000000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYCLES = CLOCK_HZ / 1000 * FLASH_HALF_MS;
	localparam int FLASH_CNT_W = 23;
	// ==========================================
	// Switch bank field positions
	localparam int SW_ADDR_LSB = 0;
	localparam int SW_ADDR_MSB = 6;
	localparam int SW_RESERVED = 7;
	localparam int SW_LINK_LO = 8;
	localparam int SW_LINK_HI = 9;
	// ==========================================
	// Image sizes and field positions
	localparam int STD_BYTES = 8;
	localparam int HW_BYTES = 4;
	localparam int XIO_IN_BYTES = 5;
	localparam int XIO_OUT_BYTES = 2;
	localparam int IN_BYTES = STD_BYTES + HW_BYTES + XIO_IN_BYTES;
	localparam int OUT_BYTES = STD_BYTES + XIO_OUT_BYTES;
	localparam int CUST_KEYS = 6;
	localparam int FEED_STOP_BIT = 22;
	localparam int FEED_ENABLE_BIT = 23;
	localparam int LED_GROUP_W = 8;
	// ==========================================
	// Reset values
	localparam logic [15:0] WHEEL_START = 16'h0000;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	// ==========================================
	// Connection type decoded from the switch bank
	typedef enum logic [1:0] {
		LINK_MULTIPOINT = 2'b00,
		LINK_FIELDBUS = 2'b01,
		LINK_INVALID = 2'b11
	} link_type_t;
	// Display mode, Gray order along flash, run, version
	typedef enum logic [1:0] {
		MODE_FLASH = 2'b00,
		MODE_RUN = 2'b01,
		MODE_VERSION = 2'b11
	} disp_mode_t;
endpackage

// file: pkg/wheel_if.sv
// Carrier between the panel top and a handwheel counter
// Assumes one clock domain
`timescale 1ns/1ns
interface wheel_if;
	logic step;
	logic dir_up;
	logic present;
	logic [15:0] count;
	modport ctr (input step, input dir_up, input present, output count);
	modport user (output step, output dir_up, output present, input count);
endinterface

// file: rtl/wheel_counter.sv
// One handwheel position counter
// Assumes steps synchronous to clock
`timescale 1ns/1ns
module wheel_counter (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Wheel
	wheel_if.ctr w
);
	logic [15:0] pos;
	logic [15:0] next_pos;

	always_comb begin
		next_pos = pos;
		if (!w.present)
			next_pos = panel_pkg::WHEEL_START; // R10
		else if (w.step)
			next_pos = w.dir_up ? pos + 16'h0001 : pos - 16'h0001; // R8
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			pos <= panel_pkg::WHEEL_START; // R8
		else if (clk_en)
			pos <= next_pos;
	end

	assign w.count = pos;

	property p_absent_zero;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && !w.present) |=> (pos == 16'h0000);
	endproperty
	a_absent_zero: assert property (p_absent_zero) else $error("Absent wheel count not zero"); // R10

	property p_step_up;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && w.present && w.step && w.dir_up) |=> (pos == $past(pos) + 16'h0001);
	endproperty
	a_step_up: assert property (p_step_up) else $error("Wheel count did not step up"); // R8
endmodule // wheel_counter

// file: rtl/panel_image.sv
// Machine control panel image logic on the fieldbus link
// Assumes inputs synchronous to clock; switch bank sampled after reset
// What this block does
// [R1] Flash every LED after power-up until cyclic communication is established.
// [R2] Feed stop plus feed enable shows version as lit-LED counts per group.
// [R3] Switches 10 and 9 both on select the fieldbus connection type.
// [R4] Switches 10 and 9 both off select the multipoint interface link.
// [R5] Installer keeps switch 8 off and uses only listed combinations.
// [R6] Switches 7 to 1 give the station address, switch 1 the LSB.
// [R7] Eight input bytes of keys and eight output bytes of lamps each cycle.
// [R8] Each handwheel reports a 16-bit count starting at zero.
// [R9] Handwheel counts go most significant byte first.
// [R10] Both counts always sent; an unconnected wheel reads zero.
// [R11] Five extra input bytes; two output bytes, low reserved zero, high customer LEDs.
// [R12] Six customer keys sit in the low bits from bit 0.
// [R13] Master's configured address must equal the switch address.
// [R14] Switch bank sampled once after reset and held.
`timescale 1ns/1ns
module panel_image (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	// Switch bank, bit 0 is position 1
	input wire logic [9:0] address_switch_bank,
	// Link status from the protocol engine
	input wire logic link_up,
	// Panel keys and switches
	input wire logic [63:0] std_keys,
	input wire logic direct_key,
	input wire logic [5:0] cust_keys,
	input wire logic [7:0] rotary_1,
	input wire logic [7:0] rotary_2,
	// Handwheels
	input wire logic [1:0] wheel_step,
	input wire logic [1:0] wheel_dir_up,
	input wire logic [1:0] wheel_present,
	// Output image from the master
	input wire logic [79:0] out_image,
	input wire logic out_valid,
	// Firmware version fields
	input wire logic [3:0] version_major,
	input wire logic [3:0] version_minor,
	input wire logic [3:0] version_patch,
	// Decoded configuration
	output logic [6:0] station_address,
	output panel_pkg::link_type_t link_type,
	output logic switch_fault,
	// Input image to the master, byte 0 in bits 7:0
	output logic [135:0] in_image,
	// Front LEDs
	output logic [63:0] std_leds,
	output logic [7:0] cust_leds,
	output panel_pkg::disp_mode_t disp_mode
);
	// ==========================================
	// Handwheel counters
	wheel_if wif [2] ();
	logic [15:0] wheel_count [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_wheel
			assign wif[g].step = wheel_step[g];
			assign wif[g].dir_up = wheel_dir_up[g];
			assign wif[g].present = wheel_present[g];
			assign wheel_count[g] = wif[g].count;
			wheel_counter u_wheel (
				.clock(clock),
				.rst_b(rst_b),
				.clk_en(clk_en),
				.w(wif[g])
			);
		end
	endgenerate

	// ==========================================
	// Switch bank capture
	logic captured;
	logic next_captured;
	logic [6:0] next_station_address;
	panel_pkg::link_type_t next_link_type;
	logic next_switch_fault;

	function automatic panel_pkg::link_type_t decode_link(input logic [9:0] sw);
		case ({sw[panel_pkg::SW_LINK_HI], sw[panel_pkg::SW_LINK_LO]})
			2'b11: decode_link = panel_pkg::LINK_FIELDBUS; // R3
			2'b00: decode_link = panel_pkg::LINK_MULTIPOINT; // R4
			default: decode_link = panel_pkg::LINK_INVALID;
		endcase
	endfunction

	always_comb begin
		next_captured = 1'b1;
		next_station_address = station_address;
		next_link_type = link_type;
		next_switch_fault = switch_fault;
		if (!captured) begin // R14
			next_station_address = address_switch_bank[panel_pkg::SW_ADDR_MSB:panel_pkg::SW_ADDR_LSB]; // R6
			next_link_type = decode_link(address_switch_bank);
			next_switch_fault = address_switch_bank[panel_pkg::SW_RESERVED]
				|| (decode_link(address_switch_bank) == panel_pkg::LINK_INVALID); // R5
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			captured <= 1'b0;
			station_address <= panel_pkg::ADDR_RESET;
			link_type <= panel_pkg::LINK_MULTIPOINT;
			switch_fault <= 1'b0;
		end else if (clk_en) begin
			captured <= next_captured;
			station_address <= next_station_address;
			link_type <= next_link_type;
			switch_fault <= next_switch_fault;
		end
	end

	// ==========================================
	// Input image assembly
	logic [135:0] next_in_image;

	always_comb begin
		next_in_image = 136'h0;
		next_in_image[63:0] = std_keys; // R7
		next_in_image[71:64] = wheel_count[0][15:8]; // R9
		next_in_image[79:72] = wheel_count[0][7:0];
		next_in_image[87:80] = wheel_count[1][15:8]; // R10
		next_in_image[95:88] = wheel_count[1][7:0];
		next_in_image[96] = direct_key; // R11
		next_in_image[109:104] = cust_keys; // R12
		next_in_image[119:112] = rotary_1;
		next_in_image[127:120] = rotary_2;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			in_image <= 136'h0;
		else if (clk_en)
			in_image <= next_in_image;
	end

	// ==========================================
	// Display mode and LEDs
	logic [22:0] flash_cnt;
	logic [22:0] next_flash_cnt;
	logic flash_on;
	logic next_flash_on;
	logic [63:0] lamp_image;
	logic [63:0] next_lamp_image;
	logic [7:0] next_cust_leds;
	logic [7:0] cust_lamp;
	logic [7:0] next_cust_lamp;
	logic [63:0] next_std_leds;
	panel_pkg::disp_mode_t next_disp_mode;
	logic version_keys;

	function automatic logic [7:0] therm(input logic [3:0] n);
		therm = 8'h00;
		for (int i = 0; i < panel_pkg::LED_GROUP_W; i++)
			if (i < int'(n))
				therm[i] = 1'b1;
	endfunction

	assign version_keys = std_keys[panel_pkg::FEED_STOP_BIT] && std_keys[panel_pkg::FEED_ENABLE_BIT];

	always_comb begin
		next_flash_cnt = flash_cnt + 23'h00_0001;
		next_flash_on = flash_on;
		if (flash_cnt == 23'(panel_pkg::FLASH_HALF_CYCLES - 1)) begin
			next_flash_cnt = 23'h00_0000;
			next_flash_on = !flash_on;
		end
		next_lamp_image = lamp_image;
		next_cust_lamp = cust_lamp;
		if (out_valid) begin
			next_lamp_image = out_image[63:0]; // R7
			next_cust_lamp = out_image[79:72]; // R11
		end
		// Stored image survives the flash phase
		next_cust_leds = next_cust_lamp;
		case (disp_mode)
			panel_pkg::MODE_FLASH:
				next_disp_mode = link_up ? panel_pkg::MODE_RUN : panel_pkg::MODE_FLASH; // R1
			panel_pkg::MODE_RUN:
				next_disp_mode = version_keys ? panel_pkg::MODE_VERSION : panel_pkg::MODE_RUN;
			panel_pkg::MODE_VERSION:
				next_disp_mode = version_keys ? panel_pkg::MODE_VERSION : panel_pkg::MODE_RUN; // R2
			default:
				next_disp_mode = panel_pkg::MODE_FLASH;
		endcase
		case (next_disp_mode)
			panel_pkg::MODE_FLASH: begin
				next_std_leds = {64{next_flash_on}}; // R1
				next_cust_leds = {8{next_flash_on}};
			end
			panel_pkg::MODE_VERSION:
				next_std_leds = {40'h00_0000_0000, therm(version_patch), therm(version_minor),
					therm(version_major)}; // R2
			default:
				next_std_leds = next_lamp_image;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flash_cnt <= 23'h00_0000;
			flash_on <= 1'b1;
			lamp_image <= 64'h0;
			cust_lamp <= 8'h00;
			cust_leds <= 8'h00;
			std_leds <= 64'h0;
			disp_mode <= panel_pkg::MODE_FLASH;
		end else if (clk_en) begin
			flash_cnt <= next_flash_cnt;
			flash_on <= next_flash_on;
			lamp_image <= next_lamp_image;
			cust_lamp <= next_cust_lamp;
			cust_leds <= next_cust_leds;
			std_leds <= next_std_leds;
			disp_mode <= next_disp_mode;
		end
	end

	// ==========================================
	// Checks
	property p_flash_all;
		@(posedge clock) disable iff (!rst_b)
		(disp_mode == panel_pkg::MODE_FLASH) |-> (std_leds == {64{std_leds[0]}});
	endproperty
	a_flash_all: assert property (p_flash_all) else $error("LEDs not flashing together"); // R1

	property p_flash_cust;
		@(posedge clock) disable iff (!rst_b)
		(disp_mode == panel_pkg::MODE_FLASH) |-> (cust_leds == {8{std_leds[0]}});
	endproperty
	a_flash_cust: assert property (p_flash_cust) else $error("Customer LEDs not flashing"); // R1

	property p_stay_flash;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && disp_mode == panel_pkg::MODE_FLASH && !link_up) |=> (disp_mode == panel_pkg::MODE_FLASH);
	endproperty
	a_stay_flash: assert property (p_stay_flash) else $error("Flash left without link"); // R1

	property p_version;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && disp_mode == panel_pkg::MODE_RUN && version_keys) |=>
			(disp_mode == panel_pkg::MODE_VERSION && std_leds[7:0] == therm($past(version_major)));
	endproperty
	a_version: assert property (p_version) else $error("Version display wrong"); // R2

	property p_version_groups;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && disp_mode == panel_pkg::MODE_RUN && version_keys) |=>
			(std_leds[23:8] == {therm($past(version_patch)), therm($past(version_minor))})
			&& (std_leds[63:24] == 40'h00_0000_0000);
	endproperty
	a_version_groups: assert property (p_version_groups) else $error("Version LED groups wrong"); // R2

	property p_link_type;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && !captured) |=>
			(link_type == ($past(address_switch_bank[9:8]) == 2'b11 ? panel_pkg::LINK_FIELDBUS :
			 $past(address_switch_bank[9:8]) == 2'b00 ? panel_pkg::LINK_MULTIPOINT : panel_pkg::LINK_INVALID));
	endproperty
	a_link_type: assert property (p_link_type) else $error("Connection type wrong"); // R3

	property p_address;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && !captured) |=> (station_address == $past(address_switch_bank[6:0]));
	endproperty
	a_address: assert property (p_address) else $error("Station address wrong"); // R6

	property p_hold;
		@(posedge clock) disable iff (!rst_b)
		captured |=> $stable(station_address) && $stable(link_type);
	endproperty
	a_hold: assert property (p_hold) else $error("Switch decode changed"); // R14

	property p_wheel_msb;
		@(posedge clock) disable iff (!rst_b)
		clk_en |=> (in_image[71:64] == $past(wheel_count[0][15:8])) && (in_image[79:72] == $past(wheel_count[0][7:0]));
	endproperty
	a_wheel_msb: assert property (p_wheel_msb) else $error("Wheel byte order wrong"); // R9

	property p_xio;
		@(posedge clock) disable iff (!rst_b)
		clk_en |=> (in_image[109:104] == $past(cust_keys)) && (in_image[111:110] == 2'b00)
			&& (in_image[63:0] == $past(std_keys));
	endproperty
	a_xio: assert property (p_xio) else $error("Input image layout wrong"); // R12

	property p_cust_leds;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && out_valid && disp_mode == panel_pkg::MODE_RUN && link_up && !version_keys) |=>
			(cust_leds == $past(out_image[79:72]));
	endproperty
	a_cust_leds: assert property (p_cust_leds) else $error("Customer LEDs wrong"); // R11

	property p_freeze;
		@(posedge clock) disable iff (!rst_b)
		!clk_en |=> $stable(disp_mode) && $stable(std_leds) && $stable(cust_leds) && $stable(in_image);
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved while clock enable low");

	c_freeze: cover property (@(posedge clock) disable iff (!rst_b) !clk_en ##1 clk_en);
	c_link: cover property (@(posedge clock) disable iff (!rst_b)
		disp_mode == panel_pkg::MODE_FLASH ##1 disp_mode == panel_pkg::MODE_RUN);
	c_version: cover property (@(posedge clock) disable iff (!rst_b) disp_mode == panel_pkg::MODE_VERSION);
	c_fieldbus: cover property (@(posedge clock) disable iff (!rst_b) link_type == panel_pkg::LINK_FIELDBUS);
endmodule // panel_image

// file: test/dp_master_model.sv
// Behavioural fieldbus master seen from the panel
// Assumes the bench calls its tasks from one process
`timescale 1ns/1ns
module dp_master_model #(
	parameter logic [6:0] CONFIG_ADDRESS = 7'h55
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Panel side
	input wire logic [135:0] in_image,
	output logic link_up,
	output logic [79:0] out_image,
	output logic out_valid
);
	logic [135:0] last_in;
	initial begin
		link_up = 1'h0;
		out_image = '0;
		out_valid = 1'h0;
	end
	always @(negedge rst_b) begin
		link_up <= 1'h0;
	end
	always @(posedge clock) begin
		last_in <= in_image;
	end
	// ==========================================
	// Link comes up only on a matching address
	task automatic bring_up(input logic [6:0] dev_addr);
		@(posedge clock);
		link_up <= (dev_addr === CONFIG_ADDRESS);
	endtask
	task automatic send_image(input logic [79:0] img);
		@(posedge clock);
		out_image <= img;
		out_valid <= 1'h1;
		@(posedge clock);
		out_valid <= 1'h0;
		// Image is not held once the strobe is gone
		out_image <= ~img;
	endtask
endmodule // dp_master_model

// file: test/testbench.sv
// Self-checking bench of the panel image block
// Assumes panel_image, wheel_counter and dp_master_model are compiled
`timescale 1ns/1ns
module testbench;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic clk_en = 1'h1;
	logic [9:0] sw = 10'h000;
	logic [63:0] std_keys = 64'h0;
	logic direct_key = 1'h0;
	logic [5:0] cust_keys = 6'h00;
	logic [7:0] rotary_1 = 8'h00;
	logic [7:0] rotary_2 = 8'h00;
	logic [1:0] wheel_step = 2'h0;
	logic [1:0] wheel_dir_up = 2'h0;
	logic [1:0] wheel_present = 2'h0;
	logic [3:0] vmaj = 4'h0;
	logic [3:0] vmin = 4'h0;
	logic [3:0] vpat = 4'h0;
	logic link_up;
	logic out_valid;
	logic [79:0] out_image;
	logic [6:0] station_address;
	panel_pkg::link_type_t link_type;
	logic switch_fault;
	logic [135:0] in_image;
	logic [63:0] std_leds;
	logic [7:0] cust_leds;
	panel_pkg::disp_mode_t disp_mode;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	localparam int CYCLE_LIMIT = 2000;
	localparam logic [79:0] LAMPS = 80'hC35A_0123_4567_89AB_CDEF;
	always #20 clock = ~clock;
	dp_master_model #(.CONFIG_ADDRESS(7'h55)) master_u (.clock(clock), .rst_b(rst_b), .in_image(in_image),
		.link_up(link_up), .out_image(out_image), .out_valid(out_valid));
	panel_image dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .address_switch_bank(sw),
		.link_up(link_up), .std_keys(std_keys), .direct_key(direct_key), .cust_keys(cust_keys),
		.rotary_1(rotary_1), .rotary_2(rotary_2), .wheel_step(wheel_step), .wheel_dir_up(wheel_dir_up),
		.wheel_present(wheel_present), .out_image(out_image), .out_valid(out_valid),
		.version_major(vmaj), .version_minor(vmin), .version_patch(vpat),
		.station_address(station_address), .link_type(link_type), .switch_fault(switch_fault),
		.in_image(in_image), .std_leds(std_leds), .cust_leds(cust_leds), .disp_mode(disp_mode));
	// ==========================================
	// Helpers
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			err_count++;
			end_sim();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input string name, input logic [135:0] exp, input logic [135:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic do_reset(input logic [9:0] sw_val);
		@(posedge clock);
		rst_b <= 1'h0;
		sw <= sw_val;
		repeat (16) @(posedge clock);
		chk("in_image in reset", '0, in_image);
		rst_b <= 1'h1;
		tick(1);
	endtask
	task automatic step(input logic [1:0] mask, input logic [1:0] up);
		@(posedge clock);
		wheel_step <= mask;
		wheel_dir_up <= up;
		@(posedge clock);
		wheel_step <= 2'h0;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_switch();
		logic [9:0] sv [6] = '{10'h355, 10'h07F, 10'h300, 10'h07E, 10'h22A, 10'h0C3};
		logic [1:0] lt [6] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0};
		logic sf [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
		for (int i = 0; i < 6; i++) begin
			do_reset(sv[i]);
			@(posedge clock);
			sw <= sv[i] ^ 10'h37F;
			tick(3);
			chk("station_address", sv[i][6:0], station_address);
			chk("link_type", lt[i], link_type);
			chk("switch_fault", sf[i], switch_fault);
		end
	endtask
	task automatic t_flash();
		do_reset(10'h355);
		chk("std_leds flash", {64{1'h1}}, std_leds);
		chk("cust_leds flash", 8'hFF, cust_leds);
		master_u.bring_up(7'h54);
		tick(4);
		chk("disp_mode flash", panel_pkg::MODE_FLASH, disp_mode);
		chk("wheel counts at start", 32'h0, in_image[95:64]);
		master_u.bring_up(7'h55);
		tick(3);
		chk("disp_mode run", panel_pkg::MODE_RUN, disp_mode);
	endtask
	task automatic t_output();
		master_u.send_image(LAMPS);
		tick(3);
		chk("std_leds", LAMPS[63:0], std_leds);
		chk("cust_leds", LAMPS[79:72], cust_leds);
	endtask
	task automatic t_input(input logic [63:0] k, input logic d, input logic [5:0] c, input logic [15:0] r);
		@(posedge clock);
		std_keys <= k;
		direct_key <= d;
		cust_keys <= c;
		{rotary_2, rotary_1} <= r;
		tick(3);
		chk("std input bytes", k, in_image[63:0]);
		chk("master std bytes", k, master_u.last_in[63:0]);
		chk("direct key byte", {7'h00, d}, in_image[103:96]);
		chk("customer key byte", {2'h0, c}, in_image[111:104]);
		chk("rotary bytes", {8'h00, r}, in_image[135:112]);
	endtask
	task automatic t_wheel();
		@(posedge clock);
		wheel_present <= 2'h1;
		step(2'h3, 2'h2);
		step(2'h3, 2'h2);
		tick(4);
		chk("wheel 0 bytes", {8'hFE, 8'hFF}, in_image[79:64]);
		chk("absent wheel bytes", 16'h0000, in_image[95:80]);
		@(posedge clock);
		wheel_present <= 2'h3;
		repeat (3) step(2'h2, 2'h2);
		tick(4);
		chk("wheel 1 bytes", 16'h0300, in_image[95:80]);
	endtask
	task automatic t_freeze();
		@(posedge clock);
		clk_en <= 1'h0;
		direct_key <= 1'h1;
		step(2'h1, 2'h1);
		tick(2);
		chk("frozen wheel bytes", {8'hFE, 8'hFF}, in_image[79:64]);
		chk("frozen direct key", 8'h00, in_image[103:96]);
		@(posedge clock);
		clk_en <= 1'h1;
		tick(2);
		chk("direct key after freeze", 8'h01, in_image[103:96]);
		chk("wheel bytes after freeze", {8'hFE, 8'hFF}, in_image[79:64]);
	endtask
	task automatic t_version();
		@(posedge clock);
		vmaj <= 4'h8;
		vmin <= 4'h2;
		vpat <= 4'h3;
		std_keys <= 64'h0000_0000_00C0_0000;
		tick(3);
		chk("disp_mode version", panel_pkg::MODE_VERSION, disp_mode);
		chk("version leds", 64'h0000_0000_0007_03FF, std_leds);
		@(posedge clock);
		std_keys <= 64'h0000_0000_0040_0000;
		tick(3);
		chk("disp_mode one key", panel_pkg::MODE_RUN, disp_mode);
		chk("lamps after version", LAMPS[63:0], std_leds);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		t_switch();
		t_flash();
		t_output();
		t_input(64'h0123_4567_89AB_CDEF, 1'h1, 6'h2D, 16'h3CA5);
		t_input(64'hFEDC_BA98_7654_3210, 1'h0, 6'h12, 16'hC35A);
		t_wheel();
		t_freeze();
		t_version();
		end_sim();
	end
endmodule // testbench
